/* src/mcu_host_mailbox_cfg.svh */
// Addresses, offsets, bit positions and reset values of the mailbox.
// Assumes one 50 MHz clock shared by the microcontroller and host ports.
// Function
// - Outbound low byte held, host readable
// - Outbound high byte at next address
// - Outbound bytes written by microcontroller only
// - Outbound ready reads 1 after high write
// - Writing 1 clears outbound ready
// - Inbound low byte written by host only
// - Registers at both address and page offset
// - Inbound high byte written by host only
// - Inbound ready set by high write, W1C
// - Enabled inbound ready interrupts microcontroller
`ifndef MCU_HOST_MAILBOX_CFG_SVH
`define MCU_HOST_MAILBOX_CFG_SVH

`define OUT_LOW_ADDR     32'h4000_0404
`define OUT_HIGH_ADDR    32'h4000_0405
`define TX_STATUS_ADDR   32'h4000_0406
`define IN_LOW_ADDR      32'h4000_0408
`define IN_HIGH_ADDR     32'h4000_0409
`define RX_STATUS_ADDR   32'h4000_040A
`define RX_ENABLE_ADDR   32'h4000_040B

`define MAILBOX_PAGE     8'h00
`define OUT_LOW_OFS      8'h04
`define OUT_HIGH_OFS     8'h05
`define TX_STATUS_OFS    8'h06
`define IN_LOW_OFS       8'h08
`define IN_HIGH_OFS      8'h09
`define RX_STATUS_OFS    8'h0A
`define RX_ENABLE_OFS    8'h0B

`define READY_BIT        0
`define BYTE_RESET       8'h00
`define FLAG_RESET       1'h0

`endif

/* src/mcu_host_mailbox_pkg.sv */
// Types shared by the mailbox design files.
// Assumes the constants header is included where numbers are needed.
package mcu_host_mailbox_pkg;

  typedef logic [7:0] byte_t;

  // One-hot register select, shared by both access ports
  typedef enum logic [7:0] {
    SEL_NONE      = 8'h00,
    SEL_OUT_LOW   = 8'h01,
    SEL_OUT_HIGH  = 8'h02,
    SEL_TX_STATUS = 8'h04,
    SEL_IN_LOW    = 8'h08,
    SEL_IN_HIGH   = 8'h10,
    SEL_RX_STATUS = 8'h20,
    SEL_RX_ENABLE = 8'h40
  } reg_sel_t;

endpackage

/* src/mailbox_flag.sv */
// Sticky ready flag with set taking priority over clear.
// Assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/10ps
`include "mcu_host_mailbox_cfg.svh"

module mailbox_flag (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  // Set wins so a word landing during a clear is never lost
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag <= `FLAG_RESET;
    end else if (set) begin
      flag <= 1'h1;
    end else if (clear) begin
      flag <= 1'h0;
    end
  end

endmodule

/* src/mcu_host_mailbox.sv */
// Two-direction byte mailbox between microcontroller and host interface.
// Assumes both ports run on clock; strobes are one-cycle, same domain.
`timescale 1ns/10ps
`include "mcu_host_mailbox_cfg.svh"

module mcu_host_mailbox (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [31:0] mcuAddr,
  input  wire logic        mcuWrite,
  input  wire logic        mcuRead,
  input  wire logic [7:0]  mcuWriteData,
  output logic      [7:0]  mcuReadData,
  output logic             mcuReadValid,
  input  wire logic [7:0]  hostPage,
  input  wire logic [7:0]  hostOffset,
  input  wire logic        hostWrite,
  input  wire logic        hostRead,
  input  wire logic [7:0]  hostWriteData,
  output logic      [7:0]  hostReadData,
  output logic             hostReadValid,
  output logic [15:0]      outboundData,
  output logic [15:0]      inboundData,
  output logic             outboundReady,
  output logic             inboundReady,
  output logic             mcuRxInterrupt
);

  mcu_host_mailbox_pkg::byte_t    outLow;
  mcu_host_mailbox_pkg::byte_t    outHigh;
  mcu_host_mailbox_pkg::byte_t    inLow;
  mcu_host_mailbox_pkg::byte_t    inHigh;
  logic                           rxIntEnable;
  mcu_host_mailbox_pkg::reg_sel_t mcuSel;
  mcu_host_mailbox_pkg::reg_sel_t hostSel;
  logic                           mcuWr;
  logic                           hostWr;
  logic                           txSet;
  logic                           txClear;
  logic                           rxSet;
  logic                           rxClear;

  // Microcontroller side decode by full address
  always_comb begin
    unique case (mcuAddr)
      `OUT_LOW_ADDR:   mcuSel = mcu_host_mailbox_pkg::SEL_OUT_LOW;
      `OUT_HIGH_ADDR:  mcuSel = mcu_host_mailbox_pkg::SEL_OUT_HIGH;
      `TX_STATUS_ADDR: mcuSel = mcu_host_mailbox_pkg::SEL_TX_STATUS;
      `IN_LOW_ADDR:    mcuSel = mcu_host_mailbox_pkg::SEL_IN_LOW;
      `IN_HIGH_ADDR:   mcuSel = mcu_host_mailbox_pkg::SEL_IN_HIGH;
      `RX_STATUS_ADDR: mcuSel = mcu_host_mailbox_pkg::SEL_RX_STATUS;
      `RX_ENABLE_ADDR: mcuSel = mcu_host_mailbox_pkg::SEL_RX_ENABLE;
      default:         mcuSel = mcu_host_mailbox_pkg::SEL_NONE;
    endcase
  end

  // Host side decode: same registers at the same offsets of page 0
  always_comb begin
    hostSel = mcu_host_mailbox_pkg::SEL_NONE;
    if (hostPage == `MAILBOX_PAGE) begin
      unique case (hostOffset)
        `OUT_LOW_OFS:   hostSel = mcu_host_mailbox_pkg::SEL_OUT_LOW;
        `OUT_HIGH_OFS:  hostSel = mcu_host_mailbox_pkg::SEL_OUT_HIGH;
        `TX_STATUS_OFS: hostSel = mcu_host_mailbox_pkg::SEL_TX_STATUS;
        `IN_LOW_OFS:    hostSel = mcu_host_mailbox_pkg::SEL_IN_LOW;
        `IN_HIGH_OFS:   hostSel = mcu_host_mailbox_pkg::SEL_IN_HIGH;
        `RX_STATUS_OFS: hostSel = mcu_host_mailbox_pkg::SEL_RX_STATUS;
        `RX_ENABLE_OFS: hostSel = mcu_host_mailbox_pkg::SEL_RX_ENABLE;
        default:        hostSel = mcu_host_mailbox_pkg::SEL_NONE;
      endcase
    end
  end

  assign mcuWr  = mcuWrite;
  assign hostWr = hostWrite;

  // Outbound bytes: host writes are dropped silently
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      outLow  <= `BYTE_RESET;
      outHigh <= `BYTE_RESET;
    end else if (mcuWr) begin
      if (mcuSel == mcu_host_mailbox_pkg::SEL_OUT_LOW) begin
        outLow <= mcuWriteData;
      end
      if (mcuSel == mcu_host_mailbox_pkg::SEL_OUT_HIGH) begin
        outHigh <= mcuWriteData;
      end
    end
  end

  // Inbound bytes: microcontroller writes are dropped silently
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inLow  <= `BYTE_RESET;
      inHigh <= `BYTE_RESET;
    end else if (hostWr) begin
      if (hostSel == mcu_host_mailbox_pkg::SEL_IN_LOW) begin
        inLow <= hostWriteData;
      end
      if (hostSel == mcu_host_mailbox_pkg::SEL_IN_HIGH) begin
        inHigh <= hostWriteData;
      end
    end
  end

  // Enable writable from either port; microcontroller wins a collision
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rxIntEnable <= `FLAG_RESET;
    end else if (mcuWr && mcuSel == mcu_host_mailbox_pkg::SEL_RX_ENABLE) begin
      rxIntEnable <= mcuWriteData[`READY_BIT];
    end else if (hostWr &&
                 hostSel == mcu_host_mailbox_pkg::SEL_RX_ENABLE) begin
      rxIntEnable <= hostWriteData[`READY_BIT];
    end
  end

  assign txSet   = mcuWr && mcuSel == mcu_host_mailbox_pkg::SEL_OUT_HIGH;
  assign rxSet   = hostWr && hostSel == mcu_host_mailbox_pkg::SEL_IN_HIGH;
  // Either side may clear; a written 0 does nothing
  assign txClear =
    (mcuWr && mcuSel == mcu_host_mailbox_pkg::SEL_TX_STATUS &&
     mcuWriteData[`READY_BIT]) ||
    (hostWr && hostSel == mcu_host_mailbox_pkg::SEL_TX_STATUS &&
     hostWriteData[`READY_BIT]);
  assign rxClear =
    (mcuWr && mcuSel == mcu_host_mailbox_pkg::SEL_RX_STATUS &&
     mcuWriteData[`READY_BIT]) ||
    (hostWr && hostSel == mcu_host_mailbox_pkg::SEL_RX_STATUS &&
     hostWriteData[`READY_BIT]);

  mailbox_flag txFlag (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (txSet),
    .clear   (txClear),
    .flag    (outboundReady)
  );

  mailbox_flag rxFlag (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (rxSet),
    .clear   (rxClear),
    .flag    (inboundReady)
  );

  function automatic mcu_host_mailbox_pkg::byte_t readMux(
    input mcu_host_mailbox_pkg::reg_sel_t sel
  );
    mcu_host_mailbox_pkg::byte_t value;
    value = `BYTE_RESET;
    unique case (sel)
      mcu_host_mailbox_pkg::SEL_NONE:      value = `BYTE_RESET;
      mcu_host_mailbox_pkg::SEL_OUT_LOW:   value = outLow;
      mcu_host_mailbox_pkg::SEL_OUT_HIGH:  value = outHigh;
      mcu_host_mailbox_pkg::SEL_TX_STATUS: value[`READY_BIT] = outboundReady;
      mcu_host_mailbox_pkg::SEL_IN_LOW:    value = inLow;
      mcu_host_mailbox_pkg::SEL_IN_HIGH:   value = inHigh;
      mcu_host_mailbox_pkg::SEL_RX_STATUS: value[`READY_BIT] = inboundReady;
      mcu_host_mailbox_pkg::SEL_RX_ENABLE: value[`READY_BIT] = rxIntEnable;
    endcase
    return value;
  endfunction

  // Read data registered: one cycle after the strobe, held until next read
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mcuReadData  <= `BYTE_RESET;
      mcuReadValid <= 1'h0;
    end else begin
      mcuReadValid <= mcuRead;
      if (mcuRead) begin
        mcuReadData <= readMux(mcuSel);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hostReadData  <= `BYTE_RESET;
      hostReadValid <= 1'h0;
    end else begin
      hostReadValid <= hostRead;
      if (hostRead) begin
        hostReadData <= readMux(hostSel);
      end
    end
  end

  // Word views are copies so the top outputs stay on flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      outboundData <= {`BYTE_RESET, `BYTE_RESET};
      inboundData  <= {`BYTE_RESET, `BYTE_RESET};
    end else begin
      outboundData <= {outHigh, outLow};
      inboundData  <= {inHigh, inLow};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mcuRxInterrupt <= 1'h0;
    end else begin
      mcuRxInterrupt <= inboundReady && rxIntEnable;
    end
  end

  // Every check below samples on clock and sleeps while reset is low
  default clocking assertClock @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  txSetFlag_a: assert property (
    txSet |=> outboundReady ##1 outboundReady || $past(txClear))
    else $error("outbound ready not set by high byte write");

  txClear_a: assert property (
    txClear && !txSet |=> !outboundReady)
    else $error("outbound ready not cleared by write of one");

  zeroNoClear_a: assert property (
    hostWr && hostSel == mcu_host_mailbox_pkg::SEL_TX_STATUS &&
    !hostWriteData[`READY_BIT] && !mcuWr && outboundReady |=> outboundReady)
    else $error("write of zero cleared outbound ready");

  hostNoOut_a: assert property (
    hostWr && !mcuWr |=> $stable(outLow) && $stable(outHigh))
    else $error("host write changed outbound bytes");

  mcuNoIn_a: assert property (
    mcuWr && !hostWr |=> $stable(inLow) && $stable(inHigh))
    else $error("microcontroller write changed inbound bytes");

  rxSetFlag_a: assert property (
    rxSet |=> inboundReady)
    else $error("inbound ready not set by high byte write");

  setWins_a: assert property (
    rxSet && rxClear |=> inboundReady)
    else $error("clear beat a simultaneous set");

  irqGate_a: assert property (
    inboundReady && rxIntEnable ##1 inboundReady && rxIntEnable
    |-> mcuRxInterrupt ##1 (mcuRxInterrupt || !$past(rxIntEnable)))
    else $error("enabled inbound ready did not interrupt");

  irqMask_a: assert property (
    !rxIntEnable |=> !mcuRxInterrupt)
    else $error("interrupt raised while disabled");

  hostOutRead_a: assert property (
    hostRead && hostSel == mcu_host_mailbox_pkg::SEL_OUT_LOW
    |=> hostReadValid && hostReadData == $past(outLow))
    else $error("host read of outbound low byte wrong");

  mcuUnmapped_a: assert property (
    mcuRead && mcuSel == mcu_host_mailbox_pkg::SEL_NONE
    |=> mcuReadValid && mcuReadData == `BYTE_RESET)
    else $error("unmapped read not zero");

endmodule

/* sim/host_port_model.sv */
// Host-side port driver standing in for the external digital interface.
// Assumes the caller invokes its tasks just after a rising clock edge.
`timescale 1ns/10ps

module host_port_model (
  output logic [7:0] hostPage,
  output logic [7:0] hostOffset,
  output logic       hostWrite,
  output logic       hostRead,
  output logic [7:0] hostWriteData
);
  initial begin
    hostPage = 8'h00;
    hostOffset = 8'h00;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostWriteData = 8'h00;
  end

  // One-cycle strobe; the bench holds address and data for that cycle
  task automatic drive(input logic [7:0] page, input logic [7:0] ofs,
                       input logic wr, input logic rd, input logic [7:0] d);
    hostPage <= page;
    hostOffset <= ofs;
    hostWrite <= wr;
    hostRead <= rd;
    hostWriteData <= d;
  endtask

  // Released offset and data lines toggle so a stale value is never mistaken for data
  task automatic idle();
    hostWrite <= 1'b0;
    hostRead <= 1'b0;
    hostOffset <= ~hostOffset;
    hostWriteData <= ~hostWriteData;
  endtask
endmodule

/* sim/test_mcu_host_mailbox.sv */
// Self-checking bench: random two-port traffic against an integer model.
// Assumes the mailbox design files and its constants header are compiled.
`timescale 1ns/10ps

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module test_mcu_host_mailbox;
  logic clock = 1'b0, reset_n = 1'b0, mcuWrite = 1'b0, mcuRead = 1'b0;
  logic [31:0] mcuAddr = 32'h0;
  logic [7:0] mcuWriteData = 8'h00, mcuReadData, hostReadData;
  logic [7:0] hostPage, hostOffset, hostWriteData;
  logic hostWrite, hostRead, mcuReadValid, hostReadValid;
  logic [15:0] outboundData, inboundData;
  logic outboundReady, inboundReady, mcuRxInterrupt;
  int n_errors = 0, checked = 0, r[7], k;
  // Register order: out low, out high, tx, in low, in high, rx, enable, hole
  int ofs[8] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h07};

  always #10 clock = ~clock;

  mcu_host_mailbox mcu_host_mailbox_inst (.clock(clock), .reset_n(reset_n),
    .mcuAddr(mcuAddr), .mcuWrite(mcuWrite), .mcuRead(mcuRead),
    .mcuWriteData(mcuWriteData), .mcuReadData(mcuReadData),
    .mcuReadValid(mcuReadValid), .hostPage(hostPage),
    .hostOffset(hostOffset), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostWriteData(hostWriteData), .hostReadData(hostReadData),
    .hostReadValid(hostReadValid), .outboundData(outboundData),
    .inboundData(inboundData), .outboundReady(outboundReady),
    .inboundReady(inboundReady), .mcuRxInterrupt(mcuRxInterrupt));

  host_port_model host_port_model_inst (.hostPage(hostPage),
    .hostOffset(hostOffset), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostWriteData(hostWriteData));

  function automatic int rdv(int i);
    if (i == 7) return 0;
    if (i == 2 || i == 5 || i == 6) return r[i] & 1;
    return r[i];
  endfunction

  task automatic check_outputs();
    `CHK("outboundData", (r[1] << 8) | r[0], outboundData)
    `CHK("inboundData", (r[4] << 8) | r[3], inboundData)
    `CHK("outboundReady", r[2], outboundReady)
    `CHK("inboundReady", r[5], inboundReady)
    `CHK("mcuRxInterrupt", r[5] & r[6], mcuRxInterrupt)
  endtask

  task automatic step(int mi, logic mw, logic mr, int md,
                      int hi, logic hw, logic hr, int hd);
    int p, i, d, clrT, clrR, setT, setR;
    logic w;
    clrT = 0; clrR = 0; setT = 0; setR = 0;
    @(posedge clock);
    mcuAddr <= 32'h4000_0400 | ofs[mi];
    mcuWrite <= mw;
    mcuRead <= mr;
    mcuWriteData <= md[7:0];
    host_port_model_inst.drive((hi == 7) ? 8'h01 : 8'h00,
      (hi == 7) ? 8'h04 : ofs[hi][7:0], hw, hr, hd[7:0]);
    @(posedge clock);
    mcuWrite <= 1'b0;
    mcuRead <= 1'b0;
    mcuWriteData <= ~mcuWriteData;
    host_port_model_inst.idle();
    @(negedge clock);
    `CHK("mcuReadValid", mr, mcuReadValid)
    `CHK("hostReadValid", hr, hostReadValid)
    if (mr) `CHK("mcuReadData", rdv(mi), mcuReadData)
    if (hr) `CHK("hostReadData", rdv(hi), hostReadData)
    // Host applied first so a microcontroller enable write wins
    for (p = 1; p >= 0; p--) begin
      i = p ? hi : mi;
      w = p ? hw : mw;
      d = p ? hd : md;
      if (!w) continue;
      case (i)
        0, 1: if (p == 0) r[i] = d;
        3, 4: if (p == 1) r[i] = d;
        2: clrT |= d & 1;
        5: clrR |= d & 1;
        6: r[6] = d & 1;
        default: ;
      endcase
      if (i == 1 && p == 0) setT = 1;
      if (i == 4 && p == 1) setR = 1;
    end
    r[2] = (r[2] & ~clrT) | setT;
    r[5] = (r[5] & ~clrR) | setR;
    @(negedge clock);
    check_outputs();
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h859f));
    r = '{default: 0};
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check_outputs();
    for (k = 0; k < 8; k++) step(k, 0, 1, 0, 7 - k, 0, 1, 0);
    step(1, 1, 0, 8'hAB, 2, 1, 0, 8'h01);
    step(5, 1, 0, 8'h01, 4, 1, 0, 8'h5C);
    step(6, 1, 0, 8'h01, 6, 1, 0, 8'h00);
    for (k = 0; k < 400; k++)
      step($urandom % 8, $urandom % 2, $urandom % 2, $urandom % 256,
           $urandom % 8, $urandom % 2, $urandom % 2, $urandom % 256);
    // Mid-run reset must wipe words, flags and the interrupt
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    r = '{default: 0};
    @(negedge clock);
    check_outputs();
    step(0, 0, 1, 0, 3, 0, 1, 0);
    print_verdict();
  end
endmodule
